//--- inc/spc_pkg.sv
// package: sensing configuration codes and constants for the sense path selector
package spc_pkg;
  localparam logic [3:0] CFG_NONE = 4'h0;
  localparam logic [3:0] CFG_1 = 4'h1;
  localparam logic [3:0] CFG_2 = 4'h2;
  localparam logic [3:0] CFG_3 = 4'h3;
  localparam logic [3:0] CFG_4 = 4'h4;
  localparam logic [3:0] CFG_5 = 4'h5;
  localparam logic [3:0] CFG_6 = 4'h6;
  localparam logic [3:0] CFG_7 = 4'h7;
  localparam logic [3:0] CFG_8 = 4'h8;
  localparam logic [3:0] CFG_9 = 4'h9;
  localparam logic [3:0] CFG_RST = 4'h6;
  // route select codes on the primary output mux
  localparam logic [1:0] RT_BEMF = 2'h0;
  localparam logic [1:0] RT_PHB = 2'h1;
  localparam logic [1:0] RT_PHA = 2'h2;
  localparam logic [1:0] RT_PHC = 2'h3;
  // sample/hold timing
  localparam int CLK_NS = 50;
  localparam int SH_PERIOD_NS = 1600;
  localparam int SH_OPEN_NS = 400;
  localparam int SH_PERIOD_CYC = SH_PERIOD_NS / CLK_NS;
  localparam int SH_OPEN_CYC = (SH_OPEN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SH_PERIOD_LAST = 8'(SH_PERIOD_CYC - 1);
  localparam logic [7:0] SH_OPEN_LAST = 8'(SH_OPEN_CYC - 1);
  typedef enum logic [1:0] {
    SH_TRACK = 2'b01,
    SH_HOLD = 2'b10
  } spc_sh_state_t;
endpackage

//--- logic/spc_selector.sv
// module: sensing configuration decode and switch routing
`timescale 1ns/1ps
`default_nettype none
module spc_selector (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic INTERFACE_SELECT_STRAP_I,
  input wire logic INPUT_STYLE_STRAP_I,
  input wire logic BACK_EMF_SENSE_ENABLE_I,
  input wire logic CURRENT_METHOD_RDSON_I,
  input wire logic CURRENT_SAMPLE_HOLD_ENABLE_I,
  input wire logic BACK_EMF_SAMPLE_HOLD_ENABLE_I,
  input wire logic BACK_EMF_COMPARATOR_OUTPUT_SEL_I,
  input wire logic BACK_EMF_PHASE_SELECT_1_I,
  input wire logic BACK_EMF_PHASE_SELECT_2_I,
  input wire logic SENSE_ROUTE_SELECT_1_I,
  input wire logic SENSE_ROUTE_SELECT_2_I,
  input wire logic LOW_SIDE_ON_A_I,
  input wire logic LOW_SIDE_ON_B_I,
  input wire logic LOW_SIDE_ON_C_I,
  output logic [3:0] CONFIG_O,
  output logic CONFIG_INVALID_O,
  output logic PHASE_A_SENSE_AMP_CURRENT_O,
  output logic PHASE_B_SENSE_AMP_CURRENT_O,
  output logic PHASE_C_SENSE_AMP_CURRENT_O,
  output logic PHASE_C_SENSE_AMP_BEMF_O,
  output logic BACK_EMF_AUX_AMP_1_EN_O,
  output logic BACK_EMF_AUX_AMP_2_EN_O,
  output logic CURRENT_SAMPLE_SW_O,
  output logic BACK_EMF_SAMPLE_SW_O,
  output logic OUTPUT_MUX_EN_O,
  output logic [1:0] PRIMARY_SENSE_OUTPUT_SEL_O,
  output logic [2:0] BACK_EMF_PHASE_O,
  output logic [2:0] SENSE_VALID_O,
  output logic COMPARATOR_OUT_EN_O
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [15:0] s1_r;
  logic [15:0] s2_r;
  wire logic [15:0] pins = {INTERFACE_SELECT_STRAP_I, INPUT_STYLE_STRAP_I, BACK_EMF_SENSE_ENABLE_I,
    CURRENT_METHOD_RDSON_I, CURRENT_SAMPLE_HOLD_ENABLE_I, BACK_EMF_SAMPLE_HOLD_ENABLE_I,
    BACK_EMF_COMPARATOR_OUTPUT_SEL_I, BACK_EMF_PHASE_SELECT_1_I, BACK_EMF_PHASE_SELECT_2_I,
    SENSE_ROUTE_SELECT_1_I, SENSE_ROUTE_SELECT_2_I, LOW_SIDE_ON_A_I, LOW_SIDE_ON_B_I,
    LOW_SIDE_ON_C_I, 2'h0};
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
    end else if (CE_I) begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire logic spi_sel = s2_r[15];
  wire logic hw_mode = s2_r[14];
  wire logic back_emf_sense_enable = s2_r[13];
  wire logic rdson = s2_r[12];
  wire logic cs_sh = s2_r[11];
  wire logic be_sh = s2_r[10];
  wire logic cmp_mode = s2_r[9];
  wire logic [1:0] phsel = s2_r[8:7];
  wire logic [1:0] rtsel = s2_r[6:5];
  // pins arrive a,b,c in the shift word; validity output is ordered c,b,a
  wire logic [2:0] ls_on = {s2_r[2], s2_r[3], s2_r[4]};

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] decode_cfg(input logic be, input logic rd, input logic cs, input logic bs,
                                            input logic cm);
    logic [3:0] c;
    c = spc_pkg::CFG_NONE;
    if (cm) c = spc_pkg::CFG_9;
    else if (be && !rd && cs && bs) c = spc_pkg::CFG_1;
    else if (be && !rd && cs && !bs) c = spc_pkg::CFG_2;
    else if (be && !rd && !cs && bs) c = spc_pkg::CFG_3;
    else if (be && !rd && !cs && !bs) c = spc_pkg::CFG_4;
    else if (!be && !rd && cs) c = spc_pkg::CFG_5;
    else if (!be && !rd && !cs) c = spc_pkg::CFG_6;
    else if (!be && rd && !cs) c = spc_pkg::CFG_7;
    else if (be && rd && !cs && !bs) c = spc_pkg::CFG_8;
    return c;
  endfunction

  function automatic logic uses_sh(input logic [3:0] c);
    return c == spc_pkg::CFG_1 || c == spc_pkg::CFG_2 || c == spc_pkg::CFG_3 ||
           c == spc_pkg::CFG_5 || c == spc_pkg::CFG_9;
  endfunction

  // hardware mode: strap picks method and back-emf, sample/hold forced off
  // method comes from the style strap, the method field is a register bit only
  wire logic [3:0] hw_cfg = decode_cfg(back_emf_sense_enable, hw_mode, 1'b0, 1'b0, 1'b0);
  wire logic [3:0] spi_cfg = decode_cfg(back_emf_sense_enable, rdson, cs_sh, be_sh, cmp_mode);
  wire logic [3:0] req_cfg = spi_sel ? spi_cfg : hw_cfg;
  // sample/hold never accepted off spi
  wire logic req_ok = (req_cfg != spc_pkg::CFG_NONE) && (spi_sel || !uses_sh(req_cfg));

  logic [3:0] cfg_r;
  logic inv_r;
  // hold last valid setting on a bad request
  wire logic [3:0] cfg_nxt = req_ok ? req_cfg : cfg_r;
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      cfg_r <= spc_pkg::CFG_RST;
      inv_r <= 1'b0;
    end else if (CE_I) begin
      cfg_r <= cfg_nxt;
      inv_r <= !req_ok;
    end
  end

  // ----------------------------------------------------------------
  // amplifier and switch routing
  // ----------------------------------------------------------------
  wire logic c_bemf = (cfg_r == spc_pkg::CFG_1) || (cfg_r == spc_pkg::CFG_2) || (cfg_r == spc_pkg::CFG_3) ||
                      (cfg_r == spc_pkg::CFG_4) || (cfg_r == spc_pkg::CFG_8) || (cfg_r == spc_pkg::CFG_9);
  wire logic c_cs_sh = (cfg_r == spc_pkg::CFG_1) || (cfg_r == spc_pkg::CFG_2) ||
                       (cfg_r == spc_pkg::CFG_5) || (cfg_r == spc_pkg::CFG_9);
  wire logic c_be_sh = (cfg_r == spc_pkg::CFG_1) || (cfg_r == spc_pkg::CFG_3) ||
                       (cfg_r == spc_pkg::CFG_9);
  // continuous configs have no mux, every chain passes through
  wire logic c_mux = c_cs_sh || c_be_sh;
  wire logic c_rdson = (cfg_r == spc_pkg::CFG_7) || (cfg_r == spc_pkg::CFG_8);
  wire logic c_cmp = (cfg_r == spc_pkg::CFG_9);
  wire logic sh_sample;

  spc_sh_timer u_sh (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .run_i(c_mux),
    .sample_o(sh_sample)
  );

  // route pins pick the buffered signal; comparator mode offers only back-emf and phase a
  wire logic [1:0] route_raw = rtsel;
  wire logic [1:0] route = c_cmp ? (route_raw[0] ? spc_pkg::RT_PHA : spc_pkg::RT_BEMF) :
                           (!c_bemf || route_raw != spc_pkg::RT_PHC) ? route_raw : spc_pkg::RT_BEMF;
  // phase select pins are one-hot decoded, 2'h3 means phase c
  wire logic [2:0] bemf_ph = !c_bemf ? 3'h0 : (phsel == 2'h1) ? 3'h1 : (phsel == 2'h2) ? 3'h2 : 3'h4;
  // on-resistance reading only good with low-side switch closed
  wire logic [2:0] valid = c_rdson ? ls_on : 3'h7;
  wire logic valid_c = c_bemf ? 1'b0 : valid[2];

  logic [17:0] out_r;
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      out_r <= 18'h0;
    end else if (CE_I) begin
      out_r <= {1'b1, !c_cmp, !c_bemf, c_bemf, c_bemf, c_bemf, c_cs_sh & sh_sample, c_be_sh & sh_sample,
                c_mux, c_mux ? route : 2'h0, bemf_ph, valid_c, valid[1:0], c_cmp};
    end
  end

  assign CONFIG_O = cfg_r;
  assign CONFIG_INVALID_O = inv_r;
  assign PHASE_A_SENSE_AMP_CURRENT_O = out_r[17];
  assign PHASE_B_SENSE_AMP_CURRENT_O = out_r[16];
  assign PHASE_C_SENSE_AMP_CURRENT_O = out_r[15];
  assign PHASE_C_SENSE_AMP_BEMF_O = out_r[14];
  assign BACK_EMF_AUX_AMP_1_EN_O = out_r[13];
  assign BACK_EMF_AUX_AMP_2_EN_O = out_r[12];
  assign CURRENT_SAMPLE_SW_O = out_r[11];
  assign BACK_EMF_SAMPLE_SW_O = out_r[10];
  assign OUTPUT_MUX_EN_O = out_r[9];
  assign PRIMARY_SENSE_OUTPUT_SEL_O = out_r[8:7];
  assign BACK_EMF_PHASE_O = out_r[6:4];
  assign SENSE_VALID_O = out_r[3:1];
  assign COMPARATOR_OUT_EN_O = out_r[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sh_needs_spi: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && !spi_sel) |=> !uses_sh(cfg_r) || cfg_r == $past(cfg_r))
    else $error("sample/hold config taken from straps");
  a_invalid_holds: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && !req_ok) |=> cfg_r == $past(cfg_r))
    else $error("invalid setting changed config");
  a_bemf_chain: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && c_bemf) |=> PHASE_C_SENSE_AMP_BEMF_O && BACK_EMF_AUX_AMP_1_EN_O && !PHASE_C_SENSE_AMP_CURRENT_O)
    else $error("back-emf chain not assigned");
  a_three_amps: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && !c_bemf && !c_cmp) |=> PHASE_A_SENSE_AMP_CURRENT_O && PHASE_B_SENSE_AMP_CURRENT_O &&
    PHASE_C_SENSE_AMP_CURRENT_O)
    else $error("phase amp not sensing current");
  a_cont_no_sh: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && !c_mux) |=> !CURRENT_SAMPLE_SW_O && !BACK_EMF_SAMPLE_SW_O && !OUTPUT_MUX_EN_O)
    else $error("continuous config uses sample/hold");
  a_cfg1_both_sh: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && cfg_r == spc_pkg::CFG_1 && sh_sample) |=> CURRENT_SAMPLE_SW_O && BACK_EMF_SAMPLE_SW_O)
    else $error("config 1 sample switches idle");
  a_cfg2_cs_only: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && cfg_r == spc_pkg::CFG_2) |=> !BACK_EMF_SAMPLE_SW_O && OUTPUT_MUX_EN_O)
    else $error("config 2 holds back-emf");
  a_cfg3_be_only: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && cfg_r == spc_pkg::CFG_3) |=> !CURRENT_SAMPLE_SW_O && OUTPUT_MUX_EN_O)
    else $error("config 3 holds current");
  a_cfg5_mux: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && cfg_r == spc_pkg::CFG_5) |=> OUTPUT_MUX_EN_O && !BACK_EMF_SAMPLE_SW_O)
    else $error("config 5 not muxed");
  a_rdson_valid: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && cfg_r == spc_pkg::CFG_7) |=> SENSE_VALID_O == $past(ls_on))
    else $error("rdson validity wrong");
  a_cmp_mode: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && spi_sel && cmp_mode) |=> cfg_r == spc_pkg::CFG_9 ##1 COMPARATOR_OUT_EN_O)
    else $error("comparator mode not entered");
  a_phase_sel: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && c_bemf && phsel == 2'h1) |=> BACK_EMF_PHASE_O == 3'h1)
    else $error("back-emf phase select ignored");
  a_route_sel: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && c_mux && !c_cmp && c_bemf && rtsel == spc_pkg::RT_PHA) |=> PRIMARY_SENSE_OUTPUT_SEL_O == spc_pkg::RT_PHA)
    else $error("route select ignored");
  a_hw_cont: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (CE_I && !spi_sel && !back_emf_sense_enable && !hw_mode) |=> cfg_r == spc_pkg::CFG_6)
    else $error("strap config not taken");
  c_cfg1: cover property (@(posedge REF_CLK_I) cfg_r == spc_pkg::CFG_1);
  c_cfg9: cover property (@(posedge REF_CLK_I) cfg_r == spc_pkg::CFG_9);
  c_hw_cfg8: cover property (@(posedge REF_CLK_I) !spi_sel && cfg_r == spc_pkg::CFG_8);
  c_invalid: cover property (@(posedge REF_CLK_I) inv_r);
endmodule // spc_selector
`default_nettype wire

//--- logic/spc_sh_timer.sv
// module: internal sample/hold switch timing
`timescale 1ns/1ps
`default_nettype none
module spc_sh_timer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic run_i,
  output logic sample_o
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  spc_pkg::spc_sh_state_t st_r;
  spc_pkg::spc_sh_state_t st_nxt;
  wire logic wrap = (cnt_r == spc_pkg::SH_PERIOD_LAST);
  wire logic open_end = (cnt_r == spc_pkg::SH_OPEN_LAST);

  always_comb begin
    cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;
    st_nxt = st_r;
    unique case (st_r)
      spc_pkg::SH_TRACK: if (open_end) st_nxt = spc_pkg::SH_HOLD;
      spc_pkg::SH_HOLD: if (wrap) st_nxt = spc_pkg::SH_TRACK;
    endcase
    if (!run_i) begin
      cnt_nxt = 8'h00;
      st_nxt = spc_pkg::SH_TRACK;
    end
  end

  // runs while run_i is high, held at zero otherwise; no external strobe needed
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_r <= 8'h00;
      st_r <= spc_pkg::SH_TRACK;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
    end
  end

  assign sample_o = run_i && (st_r == spc_pkg::SH_TRACK);

  a_sh_period: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && run_i && cnt_r == spc_pkg::SH_PERIOD_LAST && st_r == spc_pkg::SH_HOLD) |=> st_r == spc_pkg::SH_TRACK)
    else $error("sample window did not reopen");
endmodule // spc_sh_timer
`default_nettype wire

//--- sim/spc_host_model.sv
// host microcontroller model: drives the strap and field levels
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
  input wire logic clk_i,
  input wire logic spi_i,
  input wire logic [3:0] fld_i,
  input wire logic cmp_i,
  output logic ifsel_o,
  output logic style_o,
  output logic bemf_o,
  output logic rdson_o,
  output logic csh_o,
  output logic bsh_o,
  output logic cmp_o
);
  // fld_i is {bemf, rdson, cs s/h, bemf s/h}
  initial begin
    {ifsel_o, style_o, bemf_o, rdson_o, csh_o, bsh_o, cmp_o} = 7'h40;
  end
  always @(negedge clk_i) begin
    ifsel_o <= spi_i;
    style_o <= fld_i[2];
    bemf_o <= fld_i[3];
    // strap mode: method only through the style strap, field left low
    rdson_o <= spi_i & fld_i[2];
    // never asks for s/h or comparator mode through straps
    csh_o <= spi_i & fld_i[1];
    bsh_o <= spi_i & fld_i[0];
    cmp_o <= spi_i & cmp_i;
  end
endmodule // spc_host_model
`default_nettype wire

//--- sim/tb.sv
// testbench: sense path selector scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
  // fields per config 1..8, one nibble each, config 1 lowest
  localparam logic [31:0] FLD = 32'hc402_89ab;
  // expected {mux, aux amps, c on bemf, c on current}
  localparam logic [31:0] EXP = 32'h6119_6eee;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic spi = 1'b1;
  logic [3:0] fld = 4'h0;
  logic cmp = 1'b0;
  logic [1:0] phs = 2'h0;
  logic [1:0] rts = 2'h0;
  logic [2:0] lso = 3'h0;
  logic ifs, sty, bem, rds, csh, bsh, cms;
  logic inv, pac, pbc, pcc, pcb, ax1, ax2, csw, bsw, mux, coe;
  logic [3:0] cfg;
  logic [1:0] psel;
  logic [2:0] bph, vld;
  int miscompares = 0;
  int total_checks = 0;
  initial forever #25 clk = ~clk;
  spc_host_model u_host (.clk_i(clk), .spi_i(spi), .fld_i(fld), .cmp_i(cmp), .ifsel_o(ifs), .style_o(sty),
    .bemf_o(bem), .rdson_o(rds), .csh_o(csh), .bsh_o(bsh), .cmp_o(cms));
  spc_selector u_dut (.REF_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .INTERFACE_SELECT_STRAP_I(ifs),
    .INPUT_STYLE_STRAP_I(sty), .BACK_EMF_SENSE_ENABLE_I(bem), .CURRENT_METHOD_RDSON_I(rds),
    .CURRENT_SAMPLE_HOLD_ENABLE_I(csh), .BACK_EMF_SAMPLE_HOLD_ENABLE_I(bsh),
    .BACK_EMF_COMPARATOR_OUTPUT_SEL_I(cms), .BACK_EMF_PHASE_SELECT_1_I(phs[1]),
    .BACK_EMF_PHASE_SELECT_2_I(phs[0]), .SENSE_ROUTE_SELECT_1_I(rts[1]), .SENSE_ROUTE_SELECT_2_I(rts[0]),
    .LOW_SIDE_ON_A_I(lso[0]), .LOW_SIDE_ON_B_I(lso[1]), .LOW_SIDE_ON_C_I(lso[2]), .CONFIG_O(cfg),
    .CONFIG_INVALID_O(inv), .PHASE_A_SENSE_AMP_CURRENT_O(pac), .PHASE_B_SENSE_AMP_CURRENT_O(pbc),
    .PHASE_C_SENSE_AMP_CURRENT_O(pcc), .PHASE_C_SENSE_AMP_BEMF_O(pcb), .BACK_EMF_AUX_AMP_1_EN_O(ax1),
    .BACK_EMF_AUX_AMP_2_EN_O(ax2), .CURRENT_SAMPLE_SW_O(csw), .BACK_EMF_SAMPLE_SW_O(bsw),
    .OUTPUT_MUX_EN_O(mux), .PRIMARY_SENSE_OUTPUT_SEL_O(psel), .BACK_EMF_PHASE_O(bph),
    .SENSE_VALID_O(vld), .COMPARATOR_OUT_EN_O(coe));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // two sync flops plus decode: 8 cycles leaves margin over the 4 edge latency
  task automatic set_cfg(input logic s, input logic [3:0] f, input logic c);
    @(negedge clk);
    spi = s;
    fld = f;
    cmp = c;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_table();
    for (int i = 0; i < 8; i++) begin
      set_cfg(1'b1, FLD[4*i +: 4], 1'b0);
      chk(8'(cfg), 8'(i + 1));
      chk({2'h0, pac, pbc, mux, ax1 & ax2, pcb, pcc}, {4'h3, EXP[4*i +: 4]});
    end
  endtask
  // start from a config other than the reset one so a lost hold shows
  task automatic t_invalid();
    set_cfg(1'b1, 4'h4, 1'b0);
    set_cfg(1'b1, 4'h6, 1'b0);
    chk({3'h0, inv, cfg}, 8'h17);
    set_cfg(1'b1, 4'he, 1'b0);
    chk({3'h0, inv, cfg}, 8'h17);
  endtask
  task automatic t_strap();
    set_cfg(1'b0, 4'h4, 1'b0);
    chk({3'h0, inv, cfg}, 8'h07);
    set_cfg(1'b0, 4'h8, 1'b0);
    chk({3'h0, inv, cfg}, 8'h04);
    set_cfg(1'b0, 4'hb, 1'b0);
    chk({2'h0, csw, bsw, cfg}, 8'h04);
  endtask
  task automatic t_route();
    set_cfg(1'b1, 4'hb, 1'b0);
    rts = 2'h2;
    phs = 2'h1;
    repeat (6) @(negedge clk);
    chk({3'h0, bph, psel}, {3'h0, 3'h1, spc_pkg::RT_PHA});
    rts = 2'h1;
    phs = 2'h2;
    repeat (6) @(negedge clk);
    chk({3'h0, bph, psel}, {3'h0, 3'h2, spc_pkg::RT_PHB});
    phs = 2'h3;
    repeat (6) @(negedge clk);
    chk(8'(bph), 8'h4);
  endtask
  task automatic t_rdson();
    set_cfg(1'b1, 4'h4, 1'b0);
    // asymmetric patterns so a swapped phase order shows
    lso = 3'h1;
    repeat (6) @(negedge clk);
    chk(8'(vld), 8'h1);
    lso = 3'h6;
    repeat (6) @(negedge clk);
    chk(8'(vld), 8'h6);
  endtask
  task automatic t_sample();
    int n;
    n = 0;
    set_cfg(1'b1, 4'h2, 1'b0);
    // one whole period seen from any phase gives the same closed count
    repeat (spc_pkg::SH_PERIOD_CYC) begin
      @(negedge clk);
      if (csw === 1'b1) n++;
    end
    chk(8'(n), 8'(spc_pkg::SH_OPEN_CYC));
    chk(8'(bsw), 8'h0);
    n = 0;
    set_cfg(1'b1, 4'h9, 1'b0);
    repeat (spc_pkg::SH_PERIOD_CYC) begin
      @(negedge clk);
      if (bsw === 1'b1) n++;
    end
    chk(8'(n), 8'(spc_pkg::SH_OPEN_CYC));
    chk(8'(csw), 8'h0);
  endtask
  task automatic t_comp();
    set_cfg(1'b1, 4'h0, 1'b1);
    chk({3'h0, coe, cfg}, 8'h19);
    chk({4'h0, pbc, mux, psel}, {4'h0, 1'b0, 1'b1, spc_pkg::RT_PHA});
    set_cfg(1'b1, 4'h0, 1'b0);
    chk({3'h0, coe, cfg}, 8'h06);
  endtask
  // enable low: a new request must not reach the config until enable returns
  task automatic t_freeze();
    ce = 1'b0;
    set_cfg(1'b1, 4'h4, 1'b0);
    chk({3'h0, inv, cfg}, 8'h06);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    chk({3'h0, inv, cfg}, 8'h07);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    chk({3'h0, pac, cfg}, {4'h1, spc_pkg::CFG_RST});
    t_table();
    t_invalid();
    t_strap();
    t_route();
    t_rdson();
    t_sample();
    t_comp();
    t_freeze();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
